// [rtl/ascan_select.sv]
// Purpose: Scan input mask register on APB and the scan source sequencer.
// Assumes: Converter asks for each slot with step_req and takes slot_reg.
// Notes: Zero wait-state APB slave; unmapped addresses give pslverr.
//        Writes land at the access edge that completes with pready.
//
// Contract
// [R1] Upper sixteen bits of the mask register always read as zero.
// [R2] A set mask bit puts its source into the automatic scan.
// [R3] A clear mask bit is skipped by the automatic scan.
// [R4] Mask bits zero to twelve select external analog inputs of same index.
// [R5] Bit thirteen selects the charge time measurement input.
// [R6] Bit fourteen selects the internal voltage reference.
// [R7] Bit fifteen selects the ground level.
// [R8] A selected input absent on the part converts the low reference instead.
// [R9] Scan steps upward through selected bits, wrapping highest to lowest.
//
// The implementer's own choices: the APB register port and the address map.
module ascan_select
  import ascan_pkg::*;
#(
  parameter int NUM_INPUTS = ASCAN_EXT_INPUTS
) (
  input  wire logic                    ref_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ASCAN_ADDR_W-1:0] paddr,
  input  wire logic [ASCAN_DATA_W-1:0] pwdata,
  input  wire logic [3:0]              pstrb,
  output logic                         pready,
  output logic      [ASCAN_DATA_W-1:0] prdata,
  output logic                         pslverr,
  input  wire logic                    step_req,
  output ascan_slot_type               slot_reg,
  output logic                         charge_time_measurement_input,
  output logic                         internal_voltage_reference,
  output logic                         low_reference_voltage
);
  // Refuse an input count that the mask cannot describe.
  if (NUM_INPUTS < 1 || NUM_INPUTS > ASCAN_EXT_INPUTS) begin : g_bad_inputs
    $error("NUM_INPUTS out of range");
  end

  logic [ASCAN_MASK_W-1:0] scan_select_bits_reg;
  logic [ASCAN_MASK_W-1:0] scan_select_bits_next;
  logic                    scan_en_reg;
  logic                    scan_en_next;
  ascan_slot_type          slot_next;
  logic                    pready_reg;
  logic [ASCAN_DATA_W-1:0] prdata_reg;
  logic [ASCAN_DATA_W-1:0] prdata_next;
  logic                    pslverr_reg;
  logic [ASCAN_SRC_W-1:0]  pick_src;
  logic                    pick_found;

  // Bus decode; a write lands at the edge that ends its access phase.
  wire setup_ph  = psel && !penable && !pready_reg;
  wire acc_done  = psel && penable && pready_reg;
  wire hit_mask  = paddr == ASCAN_MASK_OFFSET;
  wire hit_ctrl  = paddr == ASCAN_CTRL_OFFSET;
  wire hit_stat  = paddr == ASCAN_STATUS_OFFSET;
  wire hit_any   = hit_mask || hit_ctrl || hit_stat;
  wire wr_mask   = acc_done && pwrite && hit_mask;
  wire wr_ctrl   = acc_done && pwrite && hit_ctrl;
  wire [ASCAN_DATA_W-1:0] stat_word = {23'h0, slot_reg.valid, 3'h0, slot_reg.source,
                                       slot_reg.use_low_reference_voltage};

  // Byte lane merge for the mask; upper lanes have no storage.
  assign scan_select_bits_next = {pstrb[1] ? pwdata[15:8] : scan_select_bits_reg[15:8],
                                  pstrb[0] ? pwdata[7:0] : scan_select_bits_reg[7:0]};
  assign scan_en_next = pstrb[0] ? pwdata[ASCAN_CTRL_EN_BIT] : scan_en_reg;

  // Read data; mask word is zero extended.
  assign prdata_next = hit_mask ? {16'h0000, scan_select_bits_reg} : // [R1]
                       hit_ctrl ? {31'h0, scan_en_reg} :
                       hit_stat ? stat_word : 32'h0000_0000;

  ascan_next_pick #(
    .MASK_W (ASCAN_MASK_W)
  ) u_pick (
    .mask     (scan_select_bits_reg),
    .current  (slot_reg.source),
    .next_src (pick_src),
    .found    (pick_found)
  );

  // Next slot: chosen only among set bits, cleared bits never appear.
  always_comb begin
    slot_next = slot_reg;
    if (!scan_en_reg) begin
      slot_next       = '0;
      slot_next.source = ASCAN_SRC_GROUND; // First step wraps to the lowest bit.
    end else if (step_req) begin
      slot_next.valid     = pick_found; // [R2] [R3] [R9]
      slot_next.source    = pick_src;
      // Channel without a pin converts the low reference.
      slot_next.use_low_reference_voltage = pick_found && (pick_src < ASCAN_SRC_CHARGE_TIME_MEASUREMENT_INPUT) &&
                            (32'(pick_src) >= NUM_INPUTS); // [R4] [R8]
    end
  end

  // Registers.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      scan_select_bits_reg <= ASCAN_MASK_RESET;
      scan_en_reg          <= 1'b0;
      slot_reg             <= '0;
      pready_reg           <= 1'b0;
      prdata_reg           <= '0;
      pslverr_reg          <= 1'b0;
    end else begin
      if (wr_mask) scan_select_bits_reg <= scan_select_bits_next;
      if (wr_ctrl) scan_en_reg <= scan_en_next;
      slot_reg    <= slot_next;
      pready_reg  <= setup_ph;
      prdata_reg  <= (setup_ph && !pwrite) ? prdata_next : '0;
      pslverr_reg <= setup_ph && !hit_any;
    end
  end

  // Internal source selects follow the current slot.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      charge_time_measurement_input <= 1'b0;
      internal_voltage_reference    <= 1'b0;
      low_reference_voltage         <= 1'b0;
    end else begin
      charge_time_measurement_input <= slot_next.valid &&
                                       slot_next.source == ASCAN_SRC_CHARGE_TIME_MEASUREMENT_INPUT; // [R5]
      internal_voltage_reference    <= slot_next.valid && slot_next.source == ASCAN_SRC_INTERNAL_VOLTAGE_REFERENCE; // [R6]
      low_reference_voltage         <= slot_next.valid && (slot_next.use_low_reference_voltage ||
                                       slot_next.source == ASCAN_SRC_GROUND); // [R7] [R8]
    end
  end

  assign pready  = pready_reg;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // Mask reads never show bits above the implemented sixteen.
  upper_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R1]
    pready && hit_mask && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("mask upper bits not zero");

  // A step taken on a steady mask only ever lands on a selected source.
  slot_selected_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R2]
    scan_en_reg && step_req && !wr_mask |=>
    !slot_reg.valid || scan_select_bits_reg[slot_reg.source])
    else $error("slot source not selected");

  // An empty mask gives no slot at all.
  skip_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R3]
    scan_en_reg && step_req && scan_select_bits_reg == '0 |=> !slot_reg.valid)
    else $error("empty mask gave a slot");

  // Only inputs missing on the part fall back to the low reference.
  ext_map_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R4]
    slot_reg.valid && slot_reg.use_low_reference_voltage |-> 32'(slot_reg.source) >= NUM_INPUTS)
    else $error("present input mapped to low reference");

  // Inputs present on the part convert themselves, not the low reference.
  present_in_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R4]
    slot_reg.valid && 32'(slot_reg.source) < NUM_INPUTS |-> !slot_reg.use_low_reference_voltage &&
    !low_reference_voltage)
    else $error("present input sent to low reference");

  // The charge time select follows its own slot only.
  charge_time_measurement_input_sel_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R5]
    charge_time_measurement_input |-> slot_reg.source == ASCAN_SRC_CHARGE_TIME_MEASUREMENT_INPUT)
    else $error("charge time select wrong");

  // The voltage reference select follows its own slot only.
  internal_voltage_reference_sel_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R6]
    internal_voltage_reference |-> slot_reg.valid && slot_reg.source == ASCAN_SRC_INTERNAL_VOLTAGE_REFERENCE)
    else $error("reference select wrong");

  // The ground slot puts the converter on the low level.
  ground_sel_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R7]
    slot_reg.valid && slot_reg.source == ASCAN_SRC_GROUND |-> low_reference_voltage)
    else $error("ground slot without low level");

  // With only the lowest and highest bits set, the highest wraps to the lowest.
  wrap_order_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R9]
    scan_en_reg && step_req && !wr_mask && scan_select_bits_reg == 16'h8001 &&
    slot_reg.valid && slot_reg.source == ASCAN_SRC_GROUND |=> slot_reg.source == 4'h0)
    else $error("scan did not wrap to lowest");

  // A missing input is converted at the low reference.
  missing_in_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R8]
    slot_reg.use_low_reference_voltage |-> low_reference_voltage)
    else $error("missing input not at low reference");

  // The internal source selects never overlap.
  one_select_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R5]
    $onehot0({charge_time_measurement_input, internal_voltage_reference,
              low_reference_voltage}))
    else $error("two source selects at once");

  // An idle slot drives none of the source selects.
  idle_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R3]
    !slot_reg.valid |-> !charge_time_measurement_input && !internal_voltage_reference &&
    !low_reference_voltage)
    else $error("select up without a slot");

  // Ready stands for exactly one cycle per transfer.
  ready_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pready |=> !pready)
    else $error("ready held too long");

  // Read data stays zero outside the cycle that answers a read.
  rdata_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !pready |-> prdata == '0)
    else $error("read data outside answer");

  // An error is only reported together with ready.
  err_ready_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pslverr |-> pready)
    else $error("error without ready");

  // A refused transfer leaves the mask and enable registers as they were.
  err_nowrite_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pslverr |=> $stable(scan_select_bits_reg) && $stable(scan_en_reg))
    else $error("refused write changed a register");

  // Scenarios worth seeing: writes, the charge time input, missing inputs, errors, wraps.
  cov_write_c: cover property (@(posedge ref_clk) wr_mask);
  cov_charge_time_measurement_input_c: cover property (@(posedge ref_clk) charge_time_measurement_input);
  cov_low_reference_voltage_c: cover property (@(posedge ref_clk) slot_reg.use_low_reference_voltage);
  cov_err_c: cover property (@(posedge ref_clk) pslverr);
  cov_wrap_c: cover property (@(posedge ref_clk) scan_en_reg && step_req && pick_found &&
    pick_src < slot_reg.source);
endmodule

// [pkg/ascan_pkg.sv]
// Purpose: Shared constants and types for the scan input select block.
// Assumes: 32-bit APB register bus, one aligned word per register.
// Notes: Offsets are byte addresses.
package ascan_pkg;
  localparam int          ASCAN_DATA_W        = 32;
  localparam int          ASCAN_ADDR_W        = 12;
  localparam int          ASCAN_MASK_W        = 16;
  localparam int          ASCAN_EXT_INPUTS    = 13;
  localparam int          ASCAN_SRC_W         = 4;
  localparam logic [11:0] ASCAN_MASK_OFFSET   = 12'h000;
  localparam logic [11:0] ASCAN_CTRL_OFFSET   = 12'h004;
  localparam logic [11:0] ASCAN_STATUS_OFFSET = 12'h008;
  localparam logic [15:0] ASCAN_MASK_RESET    = 16'h0000;
  localparam logic [3:0]  ASCAN_SRC_CHARGE_TIME_MEASUREMENT_INPUT      = 4'hd;
  localparam logic [3:0]  ASCAN_SRC_INTERNAL_VOLTAGE_REFERENCE     = 4'he;
  localparam logic [3:0]  ASCAN_SRC_GROUND    = 4'hf;
  localparam int          ASCAN_CTRL_EN_BIT   = 0;
  localparam int          ASCAN_ST_VALID_BIT  = 8;

  // One scan slot presented to the converter.
  typedef struct packed {
    logic       valid;
    logic [3:0] source;
    logic       use_low_reference_voltage;
  } ascan_slot_type;
endpackage

// [rtl/ascan_next_pick.sv]
// Purpose: Picks the next selected source above the current one, wrapping.
// Assumes: Combinational search, one clock domain around it.
// Notes: Result is registered in the parent.
module ascan_next_pick
  import ascan_pkg::*;
#(
  parameter int MASK_W = ASCAN_MASK_W
) (
  input  wire logic [MASK_W-1:0]      mask,
  input  wire logic [ASCAN_SRC_W-1:0] current,
  output logic      [ASCAN_SRC_W-1:0] next_src,
  output logic                        found
);
  // The wrapping search needs one mask bit for every source code.
  if (MASK_W != (1 << ASCAN_SRC_W)) begin : g_bad_width
    $error("MASK_W must match the source code range");
  end

  // Search from current+1 upward, wrapping back through zero.
  always_comb begin
    logic [ASCAN_SRC_W-1:0] idx;
    idx      = '0;
    next_src = current;
    found    = 1'b0;
    for (int k = 1; k <= MASK_W; k++) begin
      idx = current + ASCAN_SRC_W'(k);
      if (!found && mask[idx]) begin
        found    = 1'b1;
        next_src = idx;
      end
    end
  end
endmodule

// [bench/adc_scan_input_select_tb.sv]
// Purpose: Self-checking bench for the scan input mask register and its sequencer.
// Assumes: Zero wait-state APB slave; one scan step per high cycle of step_req.
// Notes: NUM_INPUTS is cut to 10 so that absent inputs are scanned too.
module adc_scan_input_select_tb
  import ascan_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    ref_clk  = 1'b0;
  logic                    sys_rst  = 1'b1;
  logic                    psel     = 1'b0;
  logic                    penable  = 1'b0;
  logic                    pwrite   = 1'b0;
  logic [ASCAN_ADDR_W-1:0] paddr    = '0;
  logic [ASCAN_DATA_W-1:0] pwdata   = '0;
  logic                    step_req = 1'b0;
  logic [3:0]              pstrb    = 4'hf;
  logic                    pready, pslverr, charge_time_measurement_input_sel, internal_voltage_reference_sel, lowref_sel, er;
  logic [31:0]             prdata, rd;
  ascan_slot_type          slot_reg;
  int                      n_fail = 0;
  int                      n_compared = 0;
  logic [63:0]             rows [4] = '{64'hffffffff_0000ffff, 64'h12345678_00005678,
                                        64'h0000a5c3_0000a5c3, 64'hffff0000_00000000};
  logic [8:0]              scan_exp [8] = '{9'h100, 9'h120, 9'h190, 9'h1b9, 9'h1d4,
                                            9'h1e2, 9'h1f1, 9'h100};

  ascan_select #(.NUM_INPUTS(10)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .step_req(step_req), .slot_reg(slot_reg),
    .charge_time_measurement_input(charge_time_measurement_input_sel), .internal_voltage_reference(internal_voltage_reference_sel),
    .low_reference_voltage(lowref_sel));

  // Free-running clock at 50 ns.
  always #25 ref_clk = ~ref_clk;

  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Requests one scan step and checks the slot that follows.
  task automatic step(input logic [8:0] exp);
    @(posedge ref_clk);
    step_req <= 1'b1;
    @(posedge ref_clk);
    step_req <= 1'b0;
    #1 check({23'h0, slot_reg, charge_time_measurement_input_sel, internal_voltage_reference_sel, lowref_sel}, {23'h0, exp});
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_fail++;
    final_report();
  end

  // Main sequence: reset, register rows, strobes, unmapped access, scan order, reset again.
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1 check({23'h0, slot_reg, charge_time_measurement_input_sel, internal_voltage_reference_sel, lowref_sel}, 32'h0);
    apb(1'b0, ASCAN_MASK_OFFSET, 32'h0);
    check(rd, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, ASCAN_MASK_OFFSET, rows[i][63:32]);
      apb(1'b0, ASCAN_MASK_OFFSET, 32'h0);
      check(rd, rows[i][31:0]);
    end
    pstrb <= 4'h2;
    apb(1'b1, ASCAN_MASK_OFFSET, 32'h0000ab12);
    pstrb <= 4'hf;
    apb(1'b0, ASCAN_MASK_OFFSET, 32'h0);
    check(rd, 32'h0000ab00);
    apb(1'b1, 12'h010, 32'h0000ffff);
    check({31'h0, er}, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    check(rd, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b0, ASCAN_MASK_OFFSET, 32'h0);
    check(rd, 32'h0000ab00);
    apb(1'b1, ASCAN_MASK_OFFSET, 32'h0000ea05);
    apb(1'b1, ASCAN_CTRL_OFFSET, 32'h1);
    for (int i = 0; i < 8; i++) begin
      step(scan_exp[i]);
      if (i == 3) begin
        apb(1'b0, ASCAN_STATUS_OFFSET, 32'h0);
        check(rd, 32'h00000117);
      end
    end
    apb(1'b1, ASCAN_CTRL_OFFSET, 32'h0);
    @(posedge ref_clk);
    #1 check({28'h0, slot_reg.valid, charge_time_measurement_input_sel, internal_voltage_reference_sel, lowref_sel}, 32'h0);
    apb(1'b1, ASCAN_MASK_OFFSET, 32'h0);
    apb(1'b1, ASCAN_CTRL_OFFSET, 32'h1);
    step(9'h0f0);
    apb(1'b1, ASCAN_MASK_OFFSET, 32'h00008001);
    step(9'h100);
    step(9'h1f1);
    step(9'h100);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1 check({23'h0, slot_reg, charge_time_measurement_input_sel, internal_voltage_reference_sel, lowref_sel}, 32'h0);
    apb(1'b0, ASCAN_MASK_OFFSET, 32'h0);
    check(rd, 32'h0);
    final_report();
  end
endmodule
